// ==== inc/cdc_pkg.sv ====
// Shared constants and types for the cable diagnostics control block.
// ==========================================================================
package cdc_pkg;
  // ========================================================================
  // Register offsets (byte addresses) and field positions.
  localparam logic [7:0] CDC_OFS_REFL = 8'h00;
  localparam logic [7:0] CDC_OFS_CFG = 8'h04;
  localparam logic [7:0] CDC_OFS_MATCH = 8'h08;
  localparam logic [7:0] CDC_OFS_TCTL = 8'h0C;
  localparam logic [7:0] CDC_OFS_TWR = 8'h10;
  localparam logic [7:0] CDC_OFS_SLICE = 8'h14;
  localparam int CDC_REFL_EN_BIT = 0;
  localparam int CDC_REFL_BUSY_BIT = 1;
  localparam int CDC_REFL_DONE_BIT = 2;
  localparam int CDC_REFL_PAIR_BIT = 3;
  localparam int CDC_REFL_NOECHO_BIT = 4;
  localparam int CDC_REFL_LEN_LSB = 8;
  localparam int CDC_CFG_XOVER_BIT = 0;
  localparam int CDC_CFG_AUTOX_BIT = 1;
  localparam int CDC_CFG_ANEG_BIT = 2;
  localparam int CDC_CFG_F100_BIT = 3;
  localparam int CDC_MATCH_VALID_BIT = 4;
  localparam int CDC_TCTL_MODE_BIT = 10;
  localparam logic [3:0] CDC_CFG_RESET = 4'h6;
  localparam logic [15:0] CDC_TWR_ROUTE = 16'h7200;
  localparam logic [15:0] CDC_TCTL_BUSEN = 16'h4401;
  // ========================================================================
  // Timing at 40 MHz.
  localparam int CDC_CLK_NS = 25;
  localparam int CDC_PULSE_NS = 50;
  localparam int CDC_LISTEN_NS = 2000;
  localparam int CDC_PULSE_CYC = (CDC_PULSE_NS + CDC_CLK_NS - 1) / CDC_CLK_NS;
  localparam int CDC_LISTEN_CYC = CDC_LISTEN_NS / CDC_CLK_NS;
  localparam int CDC_NUM_PULSES = 4;
  // ========================================================================
  // Slicer and matched length constants.
  localparam int CDC_SLICE_THR = 32;
  localparam int CDC_SLICE_REF = 64;
  localparam int CDC_SLICE_ERR_MAX = 32;
  localparam logic [3:0] CDC_MATCH_CODE_MAX = 4'hF;
  localparam int CDC_MATCH_SHIFT = 2;
  typedef enum logic [1:0] {
    CDC_ST_IDLE = 2'b00,
    CDC_ST_PULSE = 2'b01,
    CDC_ST_LISTEN = 2'b11,
    CDC_ST_DONE = 2'b10
  } cdc_tdr_state_type;
endpackage

// ==== core/cdc_slicer.sv ====
// Three-level slicer with bounded slicer error.
`timescale 1ns/1ps
module cdc_slicer import cdc_pkg::*; (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic signed [7:0] i_sample,
  output logic signed [1:0] o_symbol,
  output logic signed [6:0] o_error
);
  logic signed [1:0] sym_d;
  logic signed [6:0] err_d;
  logic signed [8:0] ideal;
  logic signed [8:0] diff;

  // Quantize the sample and clamp its distance from the ideal level.
  always_comb begin
    if (i_sample > CDC_SLICE_THR) begin
      sym_d = 2'sd1;
      ideal = 9'(CDC_SLICE_REF);
    end else if (i_sample < -CDC_SLICE_THR) begin
      sym_d = -2'sd1;
      ideal = -9'(CDC_SLICE_REF);
    end else begin
      sym_d = 2'sd0;
      ideal = 9'sd0;
    end
    diff = 9'(i_sample) - ideal;
    if (diff > CDC_SLICE_ERR_MAX) begin
      err_d = 7'(CDC_SLICE_ERR_MAX);
    end else if (diff < -CDC_SLICE_ERR_MAX) begin
      err_d = -7'(CDC_SLICE_ERR_MAX);
    end else begin
      err_d = diff[6:0];
    end
  end

  // Register the symbol and error.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_symbol <= 2'sd0;
      o_error <= 7'sd0;
    end else begin
      o_symbol <= sym_d;
      o_error <= err_d;
    end
  end
endmodule // cdc_slicer

// ==== core/cdc_tdr.sv ====
// Reflectometry pulse generator and echo interval timer.
`timescale 1ns/1ps
module cdc_tdr import cdc_pkg::*; #(
  parameter int PULSE_CYC = CDC_PULSE_CYC,
  parameter int LISTEN_CYC = CDC_LISTEN_CYC,
  parameter int NUM_PULSES = CDC_NUM_PULSES,
  parameter int LEN_W = 8
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_start,
  input wire logic i_pair,
  input wire logic i_echo,
  output logic o_tx_pulse,
  output logic o_rx_pulse,
  output logic o_busy,
  output logic o_done,
  output logic o_noecho,
  output logic [LEN_W-1:0] o_len
);
  localparam int TW = $clog2(PULSE_CYC + LISTEN_CYC + 1);
  localparam int PW = $clog2(NUM_PULSES + 1);
  cdc_tdr_state_type st_q, st_d;
  logic [TW-1:0] t_q, t_d;
  logic [PW-1:0] n_q, n_d;
  logic seen_q, seen_d;
  logic tx_d, rx_d, busy_d, done_d, noecho_d;
  logic [LEN_W-1:0] len_d;

  // Next state: pulse, listen for the echo, repeat, then report.
  always_comb begin
    st_d = st_q;
    t_d = t_q;
    n_d = n_q;
    seen_d = seen_q;
    len_d = o_len;
    noecho_d = o_noecho;
    tx_d = 1'b0;
    rx_d = 1'b0;
    done_d = 1'b0;
    case (st_q)
      CDC_ST_IDLE: begin
        if (i_start) begin
          st_d = CDC_ST_PULSE;
          t_d = '0;
          n_d = '0;
          seen_d = 1'b0;
          len_d = '0;
          noecho_d = 1'b0;
          tx_d = !i_pair;
          rx_d = i_pair;
        end
      end
      CDC_ST_PULSE: begin
        t_d = t_q + 1'b1;
        if (t_q == TW'(PULSE_CYC - 1)) begin
          st_d = CDC_ST_LISTEN;
        end else begin
          tx_d = !i_pair;
          rx_d = i_pair;
        end
      end
      CDC_ST_LISTEN: begin
        t_d = t_q + 1'b1;
        if (i_echo && !seen_q) begin
          seen_d = 1'b1;
          len_d = LEN_W'(t_q);
        end
        if (t_q == TW'(PULSE_CYC + LISTEN_CYC - 1)) begin
          if (n_q == PW'(NUM_PULSES - 1)) begin
            st_d = CDC_ST_DONE;
            done_d = 1'b1;
            noecho_d = !(seen_q || i_echo);
          end else begin
            st_d = CDC_ST_PULSE;
            n_d = n_q + 1'b1;
            t_d = '0;
            seen_d = 1'b0;
            tx_d = !i_pair;
            rx_d = i_pair;
          end
        end
      end
      CDC_ST_DONE: begin
        st_d = CDC_ST_IDLE;
      end
      default: begin
        st_d = CDC_ST_IDLE;
      end
    endcase
    busy_d = (st_d != CDC_ST_IDLE);
  end

  // State registers.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      st_q <= CDC_ST_IDLE;
      t_q <= '0;
      n_q <= '0;
      seen_q <= 1'b0;
      o_len <= '0;
      o_noecho <= 1'b0;
      o_tx_pulse <= 1'b0;
      o_rx_pulse <= 1'b0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end else begin
      st_q <= st_d;
      t_q <= t_d;
      n_q <= n_d;
      seen_q <= seen_d;
      o_len <= len_d;
      o_noecho <= noecho_d;
      o_tx_pulse <= tx_d;
      o_rx_pulse <= rx_d;
      o_busy <= busy_d;
      o_done <= done_d;
    end
  end
endmodule // cdc_tdr

// ==== core/cdc_top.sv ====
// Cable diagnostics control: Wishbone registers, reflectometry, matched length.
//
// The Wishbone slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module cdc_top import cdc_pkg::*; #(
  parameter int PULSE_CYC = CDC_PULSE_CYC,
  parameter int LISTEN_CYC = CDC_LISTEN_CYC,
  parameter int NUM_PULSES = CDC_NUM_PULSES
) (
  input wire logic I_CLK,
  input wire logic I_RESET,
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [7:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  output logic [31:0] O_WB_DAT,
  output logic O_WB_ACK,
  input wire logic I_MDIX_RESOLVED,
  input wire logic I_ECHO_TX,
  input wire logic I_ECHO_RX,
  input wire logic I_LINK_100,
  input wire logic [5:0] I_CABLE_ATTEN,
  input wire logic signed [7:0] I_RX_SAMPLE,
  output logic O_TX_PULSE,
  output logic O_RX_PULSE,
  output logic O_LINK_DROP,
  output logic [5:0] O_TEST_BUS,
  output logic O_TEST_BUS_EN
);
  // ========================================================================
  // Declarations.
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic [3:0] cfg_q, cfg_d;
  logic start_q, start_d;
  logic pair_q, pair_d;
  logic done_q, done_d;
  logic drop_q, drop_d;
  logic [15:0] tctl_q, tctl_d;
  logic [15:0] twr_q, twr_d;
  logic [1:0] tseq_q, tseq_d;
  logic tmode_q, tmode_d;
  logic [3:0] mcode_q, mcode_d;
  logic mvalid_q, mvalid_d;
  logic [5:0] tbus_q, tbus_d;
  logic tbus_en_q, tbus_en_d;
  logic req, wr_fire, sel_pair, echo, precond_ok;
  logic tdr_busy, tdr_done, tdr_noecho;
  logic [7:0] tdr_len;
  logic [5:0] atten_code;
  logic signed [1:0] slc_sym;
  logic signed [6:0] slc_err;

  // Address match, used by both the read and write paths.
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    hit = (adr[7:2] == ofs[7:2]);
  endfunction

  // Merge write data into a 16-bit register under the low byte enables.
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] sel);
    merge16 = {sel[1] ? wd[15:8] : old[15:8], sel[0] ? wd[7:0] : old[7:0]};
  endfunction

  // ========================================================================
  // Submodules.
  cdc_tdr #(
    .PULSE_CYC(PULSE_CYC),
    .LISTEN_CYC(LISTEN_CYC),
    .NUM_PULSES(NUM_PULSES),
    .LEN_W(8)
  ) u_tdr (
    .i_clk(I_CLK),
    .i_reset(I_RESET),
    .i_start(start_q),
    .i_pair(pair_q),
    .i_echo(echo),
    .o_tx_pulse(O_TX_PULSE),
    .o_rx_pulse(O_RX_PULSE),
    .o_busy(tdr_busy),
    .o_done(tdr_done),
    .o_noecho(tdr_noecho),
    .o_len(tdr_len)
  );

  cdc_slicer u_slicer (
    .i_clk(I_CLK),
    .i_reset(I_RESET),
    .i_sample(I_RX_SAMPLE),
    .o_symbol(slc_sym),
    .o_error(slc_err)
  );

  // ========================================================================
  // Bus handshake and decode helpers.
  assign req = I_WB_CYC && I_WB_STB;
  assign wr_fire = req && I_WB_WE && ack_q;
  // The tested pair follows the crossover state bit while auto crossover is off.
  assign sel_pair = cfg_q[CDC_CFG_AUTOX_BIT] ? I_MDIX_RESOLVED
                                              : cfg_q[CDC_CFG_XOVER_BIT];
  assign echo = pair_q ? I_ECHO_RX : I_ECHO_TX;
  // A test only starts once negotiation and auto crossover are off at forced 100.
  assign precond_ok = !cfg_q[CDC_CFG_AUTOX_BIT] && !cfg_q[CDC_CFG_ANEG_BIT]
                      && cfg_q[CDC_CFG_F100_BIT];
  assign atten_code = I_CABLE_ATTEN >> CDC_MATCH_SHIFT;

  // ========================================================================
  // Register file and side effects, next values.
  always_comb begin
    ack_d = req && !ack_q;
    rdat_d = rdat_q;
    cfg_d = cfg_q;
    start_d = 1'b0;
    pair_d = pair_q;
    done_d = done_q || tdr_done;
    tctl_d = tctl_q;
    twr_d = twr_q;
    tseq_d = tseq_q;
    tmode_d = tmode_q;
    if (ack_d && !I_WB_WE) begin
      rdat_d = 32'h0000_0000;
      if (hit(I_WB_ADR, CDC_OFS_REFL)) begin
        rdat_d[CDC_REFL_EN_BIT] = tdr_busy || start_q;
        rdat_d[CDC_REFL_BUSY_BIT] = tdr_busy || start_q;
        rdat_d[CDC_REFL_DONE_BIT] = done_q;
        rdat_d[CDC_REFL_PAIR_BIT] = pair_q;
        rdat_d[CDC_REFL_NOECHO_BIT] = tdr_noecho;
        rdat_d[CDC_REFL_LEN_LSB +: 8] = tdr_len;
      end else if (hit(I_WB_ADR, CDC_OFS_CFG)) begin
        rdat_d[3:0] = cfg_q;
      end else if (hit(I_WB_ADR, CDC_OFS_MATCH)) begin
        rdat_d[3:0] = mcode_q;
        rdat_d[CDC_MATCH_VALID_BIT] = mvalid_q;
      end else if (hit(I_WB_ADR, CDC_OFS_TCTL)) begin
        rdat_d[15:0] = tctl_q;
      end else if (hit(I_WB_ADR, CDC_OFS_TWR)) begin
        rdat_d[15:0] = twr_q;
      end else if (hit(I_WB_ADR, CDC_OFS_SLICE)) begin
        rdat_d[6:0] = slc_err;
        rdat_d[9:8] = slc_sym;
      end
    end
    if (wr_fire && hit(I_WB_ADR, CDC_OFS_REFL) && I_WB_SEL[0]) begin
      if (I_WB_DAT[CDC_REFL_EN_BIT] && !tdr_busy && !start_q && precond_ok) begin
        start_d = 1'b1;
        pair_d = sel_pair;
        done_d = 1'b0;
      end
    end
    if (wr_fire && hit(I_WB_ADR, CDC_OFS_CFG) && I_WB_SEL[0]) begin
      cfg_d = I_WB_DAT[3:0];
    end
    if (wr_fire && hit(I_WB_ADR, CDC_OFS_TWR)) begin
      twr_d = merge16(twr_q, I_WB_DAT, I_WB_SEL);
    end
    // Toggling the mode bit high, low, high arms the test mode.
    if (wr_fire && hit(I_WB_ADR, CDC_OFS_TCTL)) begin
      tctl_d = merge16(tctl_q, I_WB_DAT, I_WB_SEL);
      case (tseq_q)
        2'd0: tseq_d = tctl_d[CDC_TCTL_MODE_BIT] ? 2'd1 : 2'd0;
        2'd1: tseq_d = tctl_d[CDC_TCTL_MODE_BIT] ? 2'd1 : 2'd2;
        2'd2: begin
          if (tctl_d[CDC_TCTL_MODE_BIT]) begin
            tmode_d = 1'b1;
            tseq_d = 2'd0;
          end
        end
        default: tseq_d = 2'd0;
      endcase
    end
  end

  // Link-side outputs and matched length, next values.
  always_comb begin
    drop_d = tdr_busy || start_q;
    mvalid_d = I_LINK_100;
    mcode_d = mcode_q;
    if (I_LINK_100) begin
      // Codes saturate at the top so the longest supported cable still reads.
      mcode_d = (atten_code > 6'(CDC_MATCH_CODE_MAX)) ? CDC_MATCH_CODE_MAX
                                                      : atten_code[3:0];
    end
    tbus_en_d = tmode_q && (tctl_q == CDC_TCTL_BUSEN);
    tbus_d = 6'h00;
    if (tbus_en_d && twr_q == CDC_TWR_ROUTE) begin
      tbus_d = slc_err[5:0];
    end
  end

  // ========================================================================
  // State registers.
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
      cfg_q <= CDC_CFG_RESET;
      start_q <= 1'b0;
      pair_q <= 1'b0;
      done_q <= 1'b0;
      drop_q <= 1'b0;
      tctl_q <= 16'h0000;
      twr_q <= 16'h0000;
      tseq_q <= 2'd0;
      tmode_q <= 1'b0;
      mcode_q <= 4'h0;
      mvalid_q <= 1'b0;
      tbus_q <= 6'h00;
      tbus_en_q <= 1'b0;
    end else begin
      ack_q <= ack_d;
      rdat_q <= rdat_d;
      cfg_q <= cfg_d;
      start_q <= start_d;
      pair_q <= pair_d;
      done_q <= done_d;
      drop_q <= drop_d;
      tctl_q <= tctl_d;
      twr_q <= twr_d;
      tseq_q <= tseq_d;
      tmode_q <= tmode_d;
      mcode_q <= mcode_d;
      mvalid_q <= mvalid_d;
      tbus_q <= tbus_d;
      tbus_en_q <= tbus_en_d;
    end
  end

  assign O_WB_ACK = ack_q;
  assign O_WB_DAT = rdat_q;
  assign O_LINK_DROP = drop_q;
  assign O_TEST_BUS = tbus_q;
  assign O_TEST_BUS_EN = tbus_en_q;

  // ========================================================================
  // Assertions.
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RESET);

  property p_pair_sel;
    start_q |-> pair_q == $past(sel_pair);
  endproperty
  a_pair_sel: assert property (p_pair_sel) else $error("wrong pair chosen");

  property p_pulse_pair;
    (O_TX_PULSE || O_RX_PULSE) |-> (O_RX_PULSE == pair_q) && !(O_TX_PULSE && O_RX_PULSE);
  endproperty
  a_pulse_pair: assert property (p_pulse_pair) else $error("pulse on wrong pair");

  property p_pulse_width;
    $rose(O_TX_PULSE) |-> O_TX_PULSE [*2] ##1 !O_TX_PULSE;
  endproperty
  a_pulse_width: assert property (p_pulse_width) else $error("pulse width wrong");

  property p_first_pulse;
    start_q |=> (O_TX_PULSE || O_RX_PULSE) && tdr_len == 8'h00;
  endproperty
  a_first_pulse: assert property (p_first_pulse) else $error("no pulse after start");

  property p_echo_len;
    tdr_done && !tdr_noecho |-> tdr_len >= 8'(PULSE_CYC);
  endproperty
  a_echo_len: assert property (p_echo_len) else $error("length below pulse time");

  property p_link_drop;
    tdr_busy |=> O_LINK_DROP;
  endproperty
  a_link_drop: assert property (p_link_drop) else $error("link kept during test");

  property p_match_valid;
    !I_LINK_100 |=> !mvalid_q ##0 $stable(mcode_q);
  endproperty
  a_match_valid: assert property (p_match_valid) else $error("length valid without link");

  property p_match_sat;
    I_LINK_100 && I_CABLE_ATTEN >= 6'h3C |=> mcode_q == 4'hF;
  endproperty
  a_match_sat: assert property (p_match_sat) else $error("long cable code wrong");

  property p_slice_bound;
    slc_err <= 7'sd32 && slc_err >= -7'sd32;
  endproperty
  a_slice_bound: assert property (p_slice_bound) else $error("slicer error out of range");

  property p_len_hold;
    !tdr_busy && !start_q |=> $stable(tdr_len);
  endproperty
  a_len_hold: assert property (p_len_hold) else $error("length changed while idle");

  property p_test_bus;
    tbus_en_q |-> tmode_q;
  endproperty
  a_test_bus: assert property (p_test_bus) else $error("test bus without test mode");

  property p_precond;
    start_q |-> $past(precond_ok);
  endproperty
  a_precond: assert property (p_precond) else $error("start without preconditions");

  property p_ack_drop;
    O_WB_ACK |=> !O_WB_ACK;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("ack held too long");

  c_test_done: cover property (start_q ##[1:400] tdr_done);
  c_rx_pair: cover property (O_RX_PULSE);
  c_match: cover property (mvalid_q && mcode_q == 4'hF);
  c_bus_en: cover property ($rose(O_TEST_BUS_EN));
endmodule // cdc_top

// ==== testbench/cdc_cable_model.sv ====
// Cable model that reflects reflectometry pulses back on the pulsed pair.
`timescale 1ns/1ps
module cdc_cable_model (
  input wire logic i_clk,
  input wire logic i_tx_pulse,
  input wire logic i_rx_pulse,
  input wire logic i_fault,
  input wire logic [7:0] i_delay,
  output logic o_echo_tx,
  output logic o_echo_rx
);
  logic prev_q = 1'b0;
  logic pair_q = 1'b0;
  logic [7:0] cnt_q = 8'hff;
  logic hit;
  // ==========================================================================
  // Echo timing
  // Counts cycles since the last pulse began; the first pulse cycle is count zero.
  always @(posedge i_clk) begin
    prev_q <= i_tx_pulse | i_rx_pulse;
    if ((i_tx_pulse | i_rx_pulse) && !prev_q) begin
      cnt_q <= 8'h01;
      pair_q <= i_rx_pulse;
    end else if (cnt_q != 8'hff) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
  // An open or short reflects for two cycles; a terminated cable stays quiet.
  assign hit = i_fault && (cnt_q >= i_delay) && (cnt_q < i_delay + 8'h02);
  assign o_echo_tx = hit && !pair_q;
  assign o_echo_rx = hit && pair_q;
endmodule // cdc_cable_model

// ==== testbench/tb_top.sv ====
// Self-checking bench for the cable diagnostics control block.
`timescale 1ns/1ps
module tb_top import cdc_pkg::*;;
  localparam int LC = 10;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic mdix = 1'b0;
  logic link = 1'b0;
  logic fault = 1'b1;
  logic [5:0] atten = 6'h00;
  logic signed [7:0] samp = 8'h00;
  logic signed [7:0] s8;
  logic [7:0] dly = 8'h04;
  logic echo_tx, echo_rx, ack, txp, rxp, drop, ben, p;
  logic [5:0] tbus;
  logic [31:0] o_dat;
  logic [31:0] rd;
  logic [31:0] keep;
  logic [8:0] ex;
  logic ptx = 1'b0;
  logic prx = 1'b0;
  integer seed = 32'hc363;
  int failures = 0;
  int check_count = 0;
  int ntx = 0;
  int nrx = 0;
  int i;
  // ==========================================================================
  // Clock, design and cable
  // Toggles the 40 MHz clock every half period.
  always #12.5 clk = ~clk;
  cdc_top #(.PULSE_CYC(CDC_PULSE_CYC), .LISTEN_CYC(LC), .NUM_PULSES(CDC_NUM_PULSES)) cdc_top_i (
    .I_CLK(clk), .I_RESET(rst), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
    .I_WB_ADR(adr), .I_WB_SEL(4'hf), .I_WB_DAT(wdat), .O_WB_DAT(o_dat), .O_WB_ACK(ack),
    .I_MDIX_RESOLVED(mdix), .I_ECHO_TX(echo_tx), .I_ECHO_RX(echo_rx), .I_LINK_100(link),
    .I_CABLE_ATTEN(atten), .I_RX_SAMPLE(samp), .O_TX_PULSE(txp), .O_RX_PULSE(rxp),
    .O_LINK_DROP(drop), .O_TEST_BUS(tbus), .O_TEST_BUS_EN(ben));
  cdc_cable_model cdc_cable_model_i (.i_clk(clk), .i_tx_pulse(txp), .i_rx_pulse(rxp),
    .i_fault(fault), .i_delay(dly), .o_echo_tx(echo_tx), .o_echo_rx(echo_rx));
  // Counts pulses per pair at their rising edge.
  always @(posedge clk) begin
    ptx <= txp;
    prx <= rxp;
    if (txp && !ptx) ntx++;
    if (rxp && !prx) nrx++;
  end
  // ==========================================================================
  // Helpers
  // Compares one value and reports a difference at once.
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  // One classic bus cycle; holds the request until ack is sampled high at a rising edge.
  // Read data is taken at that same edge, and only then is the request released.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk);
    while (ack !== 1'b1 && n < 64) begin
      @(posedge clk);
      n++;
    end
    if (n == 64) failures++;
    rd = o_dat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  // Polls the reflectometry register until its done flag shows.
  task automatic wait_done();
    int n;
    n = 0;
    rd = 32'h0000_0000;
    while (rd[2] !== 1'b1 && n < 100) begin
      wb(1'b0, CDC_OFS_REFL, 32'h0000_0000);
      n++;
    end
    if (n == 100) failures++;
  endtask
  // Expected symbol and clamped error of the three-level slicer.
  function automatic logic [8:0] exp_slice(input logic signed [7:0] s);
    int sym;
    int e;
    sym = (s > CDC_SLICE_THR) ? 1 : ((s < -CDC_SLICE_THR) ? -1 : 0);
    e = s - sym * CDC_SLICE_REF;
    if (e > CDC_SLICE_ERR_MAX) e = CDC_SLICE_ERR_MAX;
    if (e < -CDC_SLICE_ERR_MAX) e = -CDC_SLICE_ERR_MAX;
    return {sym[1:0], e[6:0]};
  endfunction
  // Metres that software looks up for a matched length code.
  function automatic int code_m(input logic [3:0] c);
    int t [16] = '{0, 0, 0, 0, 6, 17, 27, 38, 49, 59, 70, 81, 91, 102, 113, 123};
    return t[c];
  endfunction
  // Fault distance in millimetres that software derives for an unknown cable type.
  function automatic int fault_mm(input logic [7:0] len, input logic shorted);
    return len * (shorted ? 793 : 769);
  endfunction
  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    final_report();
  end
  // ==========================================================================
  // Main sequence
  // Runs reset, refusal, reflectometry, matched length and slicer tests.
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("idle outputs", {txp, rxp, drop, ben, tbus}, 0);
    wb(1'b0, CDC_OFS_CFG, 32'h0000_0000);
    chk("cfg reset", rd[3:0], CDC_CFG_RESET);
    wb(1'b1, 8'h3c, 32'hffff_ffff);
    wb(1'b0, 8'h3c, 32'h0000_0000);
    chk("unmapped", rd, 0);
    $display("test reset done");
    wb(1'b1, CDC_OFS_REFL, 32'h0000_0001);
    repeat (8) @(negedge clk);
    wb(1'b0, CDC_OFS_REFL, 32'h0000_0000);
    chk("refused busy", rd[1:0], 0);
    chk("refused pulses", ntx + nrx, 0);
    $display("test refusal done");
    for (i = 0; i < 5; i++) begin
      p = i[0];
      @(posedge clk);
      fault <= (i != 4);
      mdix <= ~p;
      dly <= (i == 0) ? 8'h02 : (i == 3) ? 8'h09 : 8'h02 + 8'($unsigned($random(seed)) % 8);
      wb(1'b1, CDC_OFS_CFG, 32'h0000_0008 | {31'h0, p});
      ntx = 0;
      nrx = 0;
      wb(1'b1, CDC_OFS_REFL, 32'h0000_0001);
      if (i == 1) wb(1'b1, CDC_OFS_REFL, 32'h0000_0001);
      repeat (2) @(negedge clk);
      chk("link drop", drop, 1);
      wait_done();
      if (i != 4) chk("length", rd[15:8], dly);
      if (i != 4) chk("fault mm", fault_mm(rd[15:8], p), 32'(dly) * (p ? 793 : 769));
      chk("pair", rd[3], p);
      chk("no echo", rd[4], i == 4);
      chk("pulses sel", p ? nrx : ntx, CDC_NUM_PULSES);
      chk("pulses other", p ? ntx : nrx, 0);
      keep = rd;
      @(posedge clk);
      dly <= dly + 8'h01;
      repeat (20) @(negedge clk);
      chk("link back", drop, 0);
      wb(1'b0, CDC_OFS_REFL, 32'h0000_0000);
      chk("length held", rd[15:8], keep[15:8]);
    end
    $display("test reflectometry done");
    for (i = 0; i < 6; i++) begin
      @(posedge clk);
      link <= 1'b1;
      atten <= (i == 0) ? 6'h00 : (i == 1) ? 6'h3f : 6'($random(seed));
      repeat (3) @(posedge clk);
      wb(1'b0, CDC_OFS_MATCH, 32'h0000_0000);
      chk("match", rd[4:0], {1'b1, atten[5:2]});
      if (i == 1) chk("match metres", code_m(rd[3:0]), 123);
    end
    keep = {28'h0, atten[5:2]};
    @(posedge clk);
    link <= 1'b0;
    atten <= ~atten;
    repeat (3) @(posedge clk);
    wb(1'b0, CDC_OFS_MATCH, 32'h0000_0000);
    chk("match down", rd[4:0], keep[4:0]);
    $display("test matched done");
    chk("bus off", {ben, tbus}, 0);
    for (i = 0; i < 20; i++) begin
      s8 = (i == 0) ? 8'h7f : (i == 1) ? 8'h80 : 8'($random(seed));
      if (s8 == 8'h20 || s8 == 8'he0) s8 = 8'h21;
      @(posedge clk);
      samp <= s8;
      wb(1'b0, CDC_OFS_SLICE, 32'h0000_0000);
      chk("slicer", {rd[9:8], rd[6:0]}, exp_slice(s8));
      if (i == 9) begin
        wb(1'b1, CDC_OFS_TCTL, 32'h0000_0400);
        wb(1'b1, CDC_OFS_TCTL, 32'h0000_0000);
        wb(1'b1, CDC_OFS_TCTL, 32'h0000_0400);
        wb(1'b1, CDC_OFS_TWR, 32'h0000_7200);
        wb(1'b1, CDC_OFS_TCTL, 32'h0000_4401);
      end
      if (i > 9) begin
        ex = exp_slice(s8);
        repeat (3) @(negedge clk);
        chk("test bus", {ben, tbus}, {1'b1, ex[5:0]});
      end
    end
    $display("test slicer done");
    final_report();
  end
endmodule // tb_top
